// ---- hdl/qpw_map.svh ----
`ifndef QPW_MAP_SVH
`define QPW_MAP_SVH
// Contract
// RULE1: filter sample rate picked by two bits: fast/16, /32, /64, or slow oscillator
// RULE2: width counter starts on a rising edge, or on either edge when edge mode set
// RULE3: next qualifying edge pushes the count into the queue and zeroes the counter
// RULE4: an edge while saturated does not push the all-ones count
// RULE5: overflow holds the counter at all ones, sets overflow flag, requests interrupt
// RULE6: falling edge while saturated zeroes the counter and times the low pulse
// RULE7: counter clock from two bits: fast/32, /64, /128, /512 unless slow filter
// RULE8: with slow filter clock the counter runs from slow oscillator divided by two
// RULE9: software keeps the counter clock no faster than the filter sampling rate
// RULE10: results fill a six-entry queue from the first free entry onward
// RULE11: queue-full flag sets once six entries are stored
// RULE12: while full, a new result overwrites the last stored entry
// RULE13: a data read returns the oldest entry and discards it
// RULE14: the level bit updates only after the matching data byte is read
// RULE15: queue-empty flag sets when all entries are read; empty reads are undefined
// RULE16: clearing then setting enable reinitialises the queue
// RULE17: software leaves clocks, polarity and modes unchanged while enabled
// RULE18: interrupt on each rising edge, on four stored results, or on overflow
// RULE19: software checks the overflow flag first when servicing the interrupt
// RULE20: measurement continues in wait and an enabled interrupt can end wait
// RULE21: widths of one to 255 counter periods at one-period resolution
// RULE22: overrun destroys the last data; software clears by re-enabling
// RULE23: disabled block stops its clocks, clears queue and flags, frees the pin
// RULE24: polarity bit one inverts the input before measurement
// RULE25: status read with flag set then data access clears the interrupt flag
// RULE26: interrupt reaches the cpu only while interrupt enable is one

// register indices; byte address is four times the index
`define QPW_IDX_CTRL 8'h0D
`define QPW_IDX_STAT 8'h0E
`define QPW_IDX_DATA 8'h0F
`define QPW_ADR_CTRL (`QPW_IDX_CTRL << 2)
`define QPW_ADR_STAT (`QPW_IDX_STAT << 2)
`define QPW_ADR_DATA (`QPW_IDX_DATA << 2)
`define QPW_CTRL_RST 8'h0F
// control fields
`define QPW_C_EN 7
`define QPW_C_EM 6
`define QPW_C_IS 5
`define QPW_C_POL 4
`define QPW_C_CCK 2
`define QPW_C_NCK 0
// status fields
`define QPW_S_PL 7
`define QPW_S_SIG 6
`define QPW_S_IE 5
`define QPW_S_COUNT_OVERFLOW_FLAG 4
`define QPW_S_IF 3
`define QPW_S_QOR 2
`define QPW_S_QUEUE_FULL_FLAG 1
`define QPW_S_QUEUE_EMPTY_FLAG 0
// queue and counter
`define QPW_QDEPTH 6
`define QPW_IRQ_LEVEL 3'h4
`define QPW_CNT_MAX 8'hFF
// timing: slow oscillator period against the system clock
`define QPW_CLK_NS 100
`define QPW_SLOW_NS 30518
`define QPW_SLOW_DIV (`QPW_SLOW_NS / `QPW_CLK_NS)
`define QPW_RESP_OK 2'b00
`define QPW_RESP_ERR 2'b10
`endif

// ---- hdl/qpw_noise_filter.sv ----
`timescale 1ns/1ns
`default_nettype none
module qpw_noise_filter (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clr,
  input wire logic tick,
  input wire logic pin,
  output logic level_q
);
  logic s1_q;
  logic s2_q;
  logic [1:0] hist_q;
  wire agree = (s2_q == hist_q[0]) && (s2_q == hist_q[1]);
  // two-flop synchroniser; the first flop feeds only the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
    end
  end
  // level moves only after three equal samples, so glitches under two periods vanish
  always_ff @(posedge clk_sys) begin
    if (!rst_n || clr) begin
      hist_q <= 2'b00;
      level_q <= 1'b0;
    end else if (tick) begin
      hist_q <= {hist_q[0], s2_q};
      if (agree) level_q <= s2_q;
    end
  end
endmodule : qpw_noise_filter
`default_nettype wire

// ---- hdl/qpw_pkg.sv ----
package qpw_pkg;
  // counter sequencing
  typedef enum logic [1:0] {
    QPW_IDLE = 2'b00,
    QPW_RUN = 2'b01,
    QPW_SAT = 2'b10
  } qpw_cnt_e;
  typedef logic [8:0] qpw_entry_t;
endpackage : qpw_pkg

// ---- hdl/qpw_queue_mem.sv ----
`timescale 1ns/1ns
`default_nettype none
module qpw_queue_mem #(
  parameter int DEPTH = 6
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire qpw_pkg::qpw_entry_t wdata,
  input wire logic [2:0] raddr,
  output qpw_pkg::qpw_entry_t rdata_q
);
  import qpw_pkg::*;
  if (DEPTH < 2 || DEPTH > 7) begin : g_chk
    $error("queue depth must lie in 2..7");
  end
  // entries carry no reset; their content is undefined until written
  qpw_entry_t mem [DEPTH];
  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end
  // registered read port
  always_ff @(posedge clk_sys) begin
    if (!rst_n) rdata_q <= '0;
    else rdata_q <= mem[raddr];
  end
endmodule : qpw_queue_mem
`default_nettype wire

// ---- hdl/qpw_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "qpw_map.svh"
module qpw_top #(
  parameter int SLOW_DIV = `QPW_SLOW_DIV,
  parameter int QDEPTH = `QPW_QDEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic pulse_input_pin,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic measure_irq,
  output logic pin_claim
);
  import qpw_pkg::*;
  if (SLOW_DIV < 2 || SLOW_DIV > 65535) begin : g_chk
    $error("slow divider out of range");
  end
  localparam logic [2:0] QLAST = 3'(QDEPTH - 1);
  localparam logic [2:0] QFULL = 3'(QDEPTH);
  localparam logic [15:0] SLAST = 16'(SLOW_DIV - 1);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  // ************************************************************
  // registers and fields
  // ************************************************************
  logic [7:0] ctrl_q;
  logic ie_q, count_overflow_flag_q, if_q, qor_q, pl_q, arm_q;
  logic [8:0] pre_q;
  logic [15:0] sdiv_q;
  logic shalf_q;
  logic prev_q;
  logic [7:0] cnt_q;
  qpw_cnt_e st_q;
  logic [2:0] wp_q, rp_q, qn_q;
  qpw_entry_t mem_q;
  logic [7:0] awaddr_q, araddr_q;
  logic aw_have_q, w_have_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic rd_pend_q, pop_pend_q;
  logic sig;

  wire en = ctrl_q[`QPW_C_EN];
  wire em = ctrl_q[`QPW_C_EM];
  wire isel = ctrl_q[`QPW_C_IS];
  wire input_invert = ctrl_q[`QPW_C_POL];
  wire [1:0] cck = ctrl_q[`QPW_C_CCK +: 2];
  wire [1:0] nck = ctrl_q[`QPW_C_NCK +: 2];

  // ************************************************************
  // rate generation from the fast and slow oscillators
  // ************************************************************
  // the fast oscillator is the system clock; dividers are tap decodes
  wire t16 = &pre_q[3:0];
  wire t32 = &pre_q[4:0];
  wire t64 = &pre_q[5:0];
  wire t128 = &pre_q[6:0];
  wire t512 = &pre_q[8:0];
  wire slow_tick = (sdiv_q == SLAST);
  wire slow2_tick = slow_tick & shalf_q;
  wire ntick;
  wire ctick;
  assign ntick = (nck == 2'b00) ? t16 : (nck == 2'b01) ? t32 :
                 (nck == 2'b10) ? t64 : slow_tick; // RULE1
  // a slow filter clock overrides the counter clock choice
  assign ctick = (nck == 2'b11) ? slow2_tick : // RULE8
                 (cck == 2'b00) ? t32 : (cck == 2'b01) ? t64 :
                 (cck == 2'b10) ? t128 : t512; // RULE7

  // dividers held at zero while disabled, the block's clocks stand still
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin // RULE23
      pre_q <= '0;
      sdiv_q <= '0;
      shalf_q <= 1'b0;
    end else begin
      pre_q <= pre_q + 9'h001;
      sdiv_q <= slow_tick ? 16'h0000 : sdiv_q + 16'h0001;
      if (slow_tick) shalf_q <= ~shalf_q;
    end
  end

  // ************************************************************
  // input filter and edge detection
  // ************************************************************
  logic filt;
  qpw_noise_filter u_filt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clr(!en),
    .tick(ntick),
    .pin(pulse_input_pin),
    .level_q(filt)
  );
  assign sig = filt ^ input_invert; // RULE24
  wire rise = sig & ~prev_q;
  wire fall = ~sig & prev_q;
  wire qual = rise | (em & fall); // RULE2

  // history follows the idle level while disabled, so enabling with inversion set
  // does not see a false rising edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) prev_q <= 1'b0;
    else prev_q <= sig; // RULE24
  end

  // ************************************************************
  // width counter
  // ************************************************************
  // qual wins over a counter tick in the same cycle
  wire push = (st_q == QPW_RUN) && qual; // RULE3 RULE4
  wire ovf = (st_q == QPW_RUN) && !qual && ctick && (cnt_q == `QPW_CNT_MAX);
  wire restart = (st_q == QPW_IDLE) ? qual : (st_q == QPW_SAT) ? (qual | fall) : 1'b0;

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin
      st_q <= QPW_IDLE;
      cnt_q <= 8'h00;
    end else begin
      case (st_q)
        QPW_IDLE: begin
          if (restart) begin // RULE2
            st_q <= QPW_RUN;
            cnt_q <= 8'h00;
          end
        end
        QPW_RUN: begin
          if (qual) cnt_q <= 8'h00; // RULE3
          else if (ovf) st_q <= QPW_SAT; // RULE5
          else if (ctick) cnt_q <= cnt_q + 8'h01; // RULE21
        end
        QPW_SAT: begin
          // count held at all ones; a falling edge times the low pulse
          if (restart) begin // RULE6 RULE4
            st_q <= QPW_RUN;
            cnt_q <= 8'h00;
          end
        end
        default: st_q <= QPW_IDLE;
      endcase
    end
  end

  // ************************************************************
  // result queue
  // ************************************************************
  wire rd_take = s_axi_arvalid & s_axi_arready;
  wire rd_data = (s_axi_araddr == `QPW_ADR_DATA);
  wire rd_stat = (s_axi_araddr == `QPW_ADR_STAT);
  wire queue_empty_flag = (qn_q == 3'h0);
  wire qfull = (qn_q == QFULL);
  wire pop = rd_take & rd_data & !queue_empty_flag; // RULE13
  wire ovw = push & qfull & !pop;
  wire [2:0] wp_prev = (wp_q == 3'h0) ? QLAST : wp_q - 3'h1;
  wire [2:0] waddr = ovw ? wp_prev : wp_q; // RULE10 RULE12
  wire [2:0] qn_d = qn_q + {2'b00, push & !ovw} - {2'b00, pop};
  wire at_level = (qn_d == `QPW_IRQ_LEVEL) && (qn_q != `QPW_IRQ_LEVEL);
  // the stored level is the one that just ended
  wire qpw_entry_t wentry = {prev_q, cnt_q};

  qpw_queue_mem #(.DEPTH(QDEPTH)) u_mem (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .we(push),
    .waddr(waddr),
    .wdata(wentry),
    .raddr(rp_q),
    .rdata_q(mem_q)
  );

  // pointers cleared while disabled so re-enabling starts empty
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin // RULE16 RULE23
      wp_q <= 3'h0;
      rp_q <= 3'h0;
      qn_q <= 3'h0;
      qor_q <= 1'b0;
    end else begin
      if (push & !ovw) wp_q <= (wp_q == QLAST) ? 3'h0 : wp_q + 3'h1;
      if (pop) rp_q <= (rp_q == QLAST) ? 3'h0 : rp_q + 3'h1;
      qn_q <= qn_d; // RULE11 RULE15
      if (ovw) qor_q <= 1'b1; // RULE22
    end
  end

  // ************************************************************
  // flags and interrupt
  // ************************************************************
  wire wr_do = aw_have_q & w_have_q & !s_axi_bvalid;
  wire wr_data = (awaddr_q == `QPW_ADR_DATA);
  wire data_acc = (rd_take & rd_data) | (wr_do & wr_data);
  wire if_set = ovf | (isel ? rise : (push & !ovw & at_level)); // RULE18
  wire if_clr = arm_q & data_acc; // RULE25

  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en) begin // RULE23
      count_overflow_flag_q <= 1'b0;
      if_q <= 1'b0;
      arm_q <= 1'b0;
      pl_q <= 1'b0;
    end else begin
      if (ovf) count_overflow_flag_q <= 1'b1; // RULE5
      // a new event wins over a clear in the same cycle
      if (if_set) if_q <= 1'b1;
      else if (if_clr) if_q <= 1'b0;
      if (rd_take & rd_stat & if_q) arm_q <= 1'b1;
      else if (data_acc) arm_q <= 1'b0;
      // level follows the byte once the read has delivered it
      if (rd_pend_q & pop_pend_q) pl_q <= mem_q[8]; // RULE14
    end
  end

  // request leaves the block only while enabled; it also ends wait
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      measure_irq <= 1'b0;
      pin_claim <= 1'b0;
    end else begin
      measure_irq <= if_q & ie_q; // RULE26 RULE20
      pin_claim <= en; // RULE23
    end
  end

  // ************************************************************
  // register bus slave
  // ************************************************************
  logic [7:0] stat_v;
  assign stat_v[`QPW_S_PL] = pl_q;
  assign stat_v[`QPW_S_SIG] = sig;
  assign stat_v[`QPW_S_IE] = ie_q;
  assign stat_v[`QPW_S_COUNT_OVERFLOW_FLAG] = count_overflow_flag_q;
  assign stat_v[`QPW_S_IF] = if_q;
  assign stat_v[`QPW_S_QOR] = qor_q;
  assign stat_v[`QPW_S_QUEUE_FULL_FLAG] = qfull;
  assign stat_v[`QPW_S_QUEUE_EMPTY_FLAG] = queue_empty_flag; // RULE15
  wire ra_ctrl = (araddr_q == `QPW_ADR_CTRL);
  wire ra_stat = (araddr_q == `QPW_ADR_STAT);
  wire ra_data = (araddr_q == `QPW_ADR_DATA);
  wire ra_hit = ra_ctrl | ra_stat | ra_data;
  wire [7:0] rbyte = ra_ctrl ? ctrl_q : ra_stat ? stat_v : ra_data ? mem_q[7:0] : 8'h00;
  wire wa_ctrl = (awaddr_q == `QPW_ADR_CTRL);
  wire wa_stat = (awaddr_q == `QPW_ADR_STAT);
  wire wa_hit = wa_ctrl | wa_stat | wr_data;

  // write channels taken in either order, response once both held
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid & !s_axi_awready & !aw_have_q;
      s_axi_wready <= s_axi_wvalid & !s_axi_wready & !w_have_q;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_do) aw_have_q <= 1'b0;
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wstrb0_q <= s_axi_wstrb[0];
      end else if (wr_do) w_have_q <= 1'b0;
    end
  end

  // register writes; only byte lane 0 carries data
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl_q <= `QPW_CTRL_RST;
      ie_q <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `QPW_RESP_OK;
    end else begin
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wa_hit ? `QPW_RESP_OK : `QPW_RESP_ERR;
        if (wa_ctrl & wstrb0_q) ctrl_q <= wdata_q;
        if (wa_stat & wstrb0_q) ie_q <= wdata_q[`QPW_S_IE];
      end else if (s_axi_bready) s_axi_bvalid <= 1'b0;
    end
  end

  // reads answer one edge after the take so queue data come from a flop
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `QPW_RESP_OK;
      rd_pend_q <= 1'b0;
      pop_pend_q <= 1'b0;
      araddr_q <= 8'h00;
    end else begin
      s_axi_arready <= s_axi_arvalid & !s_axi_arready & !rd_pend_q & !s_axi_rvalid;
      rd_pend_q <= rd_take;
      pop_pend_q <= pop;
      if (rd_take) araddr_q <= s_axi_araddr;
      if (rd_pend_q) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rbyte};
        s_axi_rresp <= ra_hit ? `QPW_RESP_OK : `QPW_RESP_ERR;
      end else if (s_axi_rready) s_axi_rvalid <= 1'b0;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  ovf_sat_a: assert property (ovf && en |=> st_q == QPW_SAT && count_overflow_flag_q && cnt_q == 8'hFF) // RULE5
    else $error("overflow did not saturate");
  sat_push_a: assert property (st_q == QPW_SAT |-> !push) // RULE4
    else $error("saturated count pushed");
  push_zero_a: assert property (push && en |=> cnt_q == 8'h00 && st_q == QPW_RUN) // RULE3
    else $error("counter not cleared after push");
  full_flag_a: assert property (push && !pop && qn_q == QLAST && en |=> qfull) // RULE11
    else $error("queue full flag missing");
  last_empty_a: assert property (pop && !push && qn_q == 3'h1 && en |=> queue_empty_flag) // RULE15
    else $error("queue empty flag missing");
  overrun_keep_a: assert property (ovw && en |=> qor_q && qn_q == QFULL) // RULE12
    else $error("overrun handling wrong");
  disable_clr_a: assert property (!en |=> qn_q == 3'h0 && !count_overflow_flag_q && !if_q && !qor_q) // RULE23
    else $error("disable left state behind");
  irq_gate_a: assert property (measure_irq |-> $past(ie_q) && $past(if_q)) // RULE26
    else $error("interrupt without enable");
  pl_hold_a: assert property (!rd_pend_q && en && $past(en) |=> $stable(pl_q)) // RULE14
    else $error("level bit moved without read");
endmodule : qpw_top
`default_nettype wire

// ---- verification/qpw_pulse_src.sv ----
`timescale 1ns/1ns
`default_nettype none
// ********
// external pulse source
// ********
module qpw_pulse_src (
  input wire logic clk_sys,
  input wire logic go,
  input wire logic [15:0] hi_cyc,
  input wire logic [15:0] lo_cyc,
  output logic pin,
  output logic busy
);
  // pin rests low between pulses, like an idle open input with pull-down;
  // one high phase then one low phase per request; requests while busy are ignored
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go && !busy) begin
        busy <= 1'b1;
        pin <= 1'b1;
        repeat (hi_cyc) @(posedge clk_sys);
        pin <= 1'b0;
        repeat (lo_cyc) @(posedge clk_sys);
        busy <= 1'b0;
      end
    end
  end
endmodule : qpw_pulse_src
`default_nettype wire

// ---- verification/qpw_tb_top.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "qpw_map.svh"
module qpw_tb_top;
  import qpw_pkg::*;
  // ********
  // signals
  // ********
  localparam logic [7:0] a_ctl = `QPW_ADR_CTRL, a_st = `QPW_ADR_STAT, a_dat = `QPW_ADR_DATA;
  localparam logic [31:0] c_en = 32'h80, c_edge = 32'h40, c_isel = 32'h20, c_inv = 32'h10;
  localparam logic [31:0] c_slow = 32'h03, s_lvl = 32'h80, s_filt = 32'h40, s_ien = 32'h20;
  localparam logic [31:0] s_ovf = 32'h10, s_irq = 32'h08, s_orun = 32'h04, s_full = 32'h02;
  localparam logic [31:0] s_emp = 32'h01;
  logic clk_sys, rst_n, pin, go, busy, irq, claim;
  logic [15:0] hi_cyc, lo_cyc;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp_v;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  int error_cnt, checks, cyc;

  // slow oscillator shortened to four system clocks to keep runs short
  qpw_top #(.SLOW_DIV(4)) u_qpw_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .pulse_input_pin(pin),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .measure_irq(irq),
    .pin_claim(claim)
  );
  qpw_pulse_src u_qpw_pulse_src (
    .clk_sys(clk_sys), .go(go), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
    .pin(pin), .busy(busy)
  );

  // ********
  // bus and compare tasks
  // ********
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : step
  // widths depend on filter phase, so a tolerance in counter ticks is allowed
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input int tol);
    checks++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // address and data offered together, each released when its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    resp_v = bresp;
    bready <= 1'b0;
    // one edge passes before a following request raises bready again
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    resp_v = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : rd
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input int t);
    rd(a);
    chk(rd_v & m, e, t);
  endtask : rdc
  // settings change only with the block disabled
  task automatic cfg(input logic [31:0] c);
    wr(a_ctl, c & 32'h7F);
    wr(a_ctl, c);
  endtask : cfg
  task automatic burst(input int h, input int l);
    hi_cyc <= 16'(h);
    lo_cyc <= 16'(l);
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy) @(posedge clk_sys);
  endtask : burst
  task automatic close_out();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out

  // ********
  // scenarios
  // ********
  task automatic t_reset();
    rdc(a_ctl, `QPW_CTRL_RST, 32'hFF, 0);
    rdc(a_st, s_emp, 32'hBF, 0);
    rd(8'h00);
    chk(32'(resp_v), 32'(`QPW_RESP_ERR), 0);
    wr(8'h00, 32'h0000_0000);
    chk(32'(resp_v), 32'(`QPW_RESP_ERR), 0);
    chk(32'(claim), 0, 0);
  endtask : t_reset
  task automatic t_inv();
    cfg(c_en | c_isel | c_inv | c_slow);
    step(60);
    rdc(a_st, s_filt | s_emp, s_filt | s_emp | s_irq, 0);
    chk(32'(claim), 1, 0);
    cfg(c_en | c_slow);
    step(60);
    rdc(a_st, s_emp, s_filt | s_emp, 0);
  endtask : t_inv
  // fast clocks, both edges: 320 and 640 cycles at 32 cycles per tick
  task automatic t_both();
    cfg(c_en | c_edge | c_isel);
    burst(320, 640);
    burst(320, 640);
    step(120);
    rdc(a_st, s_irq, s_irq | s_lvl, 0);
    rdc(a_dat, 10, 32'hFF, 1);
    rdc(a_st, s_lvl, s_lvl, 0);
    rdc(a_dat, 20, 32'hFF, 1);
    rdc(a_st, 0, s_lvl, 0);
    rdc(a_dat, 10, 32'hFF, 1);
    rdc(a_st, s_lvl | s_emp, s_lvl | s_emp, 0);
  endtask : t_both
  // seven results into six places: the last one replaces the newest
  task automatic t_full();
    cfg(c_en | c_edge | c_slow);
    repeat (3) burst(40, 40);
    burst(120, 40);
    step(60);
    rdc(a_st, s_full | s_orun | s_irq, s_full | s_orun | s_irq | s_emp, 0);
    chk(32'(irq), 0, 0);
    wr(a_st, s_ien);
    step(2);
    chk(32'(irq), 1, 0);
    rd(a_st);
    for (int i = 0; i < 6; i++) rdc(a_dat, (i == 5) ? 15 : 5, 32'hFF, 1);
    step(2);
    chk(32'(irq), 0, 0);
    rdc(a_st, s_emp, s_emp | s_full, 0);
    burst(40, 40);
    step(60);
    cfg(c_en | c_edge | c_slow);
    rdc(a_st, s_emp, s_emp | s_orun | s_irq | s_ovf | s_lvl, 0);
  endtask : t_full
  // slow counter at 8 cycles a tick saturates after 2048 cycles
  task automatic t_ovf();
    cfg(c_en | c_edge | c_slow);
    wr(a_st, s_ien);
    burst(2200, 80);
    burst(40, 40);
    step(60);
    chk(32'(irq), 1, 0);
    rdc(a_st, s_ovf | s_irq, s_ovf | s_irq | s_emp, 0);
    rdc(a_dat, 10, 32'hFF, 1);
    step(2);
    chk(32'(irq), 0, 0);
    rdc(a_dat, 5, 32'hFF, 1);
    rdc(a_st, s_ovf | s_emp | s_lvl, s_ovf | s_emp | s_lvl, 0);
  endtask : t_ovf

  // clock and hang guard
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  initial begin
    cyc = 0;
    forever begin
      @(posedge clk_sys);
      cyc++;
      if (cyc == 30000) begin
        error_cnt++;
        close_out();
      end
    end
  end
  // main sequence
  initial begin
    rst_n = 1'b0;
    go = 1'b0;
    hi_cyc = 16'h0000;
    lo_cyc = 16'h0000;
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h00000000;
    wstrb = 4'h1;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    t_reset();
    t_inv();
    t_both();
    t_full();
    t_ovf();
    close_out();
  end
endmodule : qpw_tb_top
`default_nettype wire
